// ### verilog/eeac_defines.vh
// eeprom access control: register offsets, fields, reset values, timing
`ifndef EEAC_DEFINES_VH
`define EEAC_DEFINES_VH

// =====================================================================
// register byte offsets
`define EEAC_ADDR_OFS      12'h000
`define EEAC_DATA_OFS      12'h004
`define EEAC_CTRL_OFS      12'h008
`define EEAC_STAT_OFS      12'h00C

// =====================================================================
// control register fields
`define EEAC_CTRL_RSTRB    0
`define EEAC_CTRL_WSTRB    1
`define EEAC_CTRL_MWE      2
`define EEAC_CTRL_RIE      3
`define EEAC_CTRL_PM_LO    4
`define EEAC_CTRL_PM_HI    5

// =====================================================================
// status register fields
`define EEAC_STAT_BUSY     0
`define EEAC_STAT_SPM      1
`define EEAC_STAT_IRQ      2

// =====================================================================
// program modes
`define EEAC_PM_ATOMIC     2'h0
`define EEAC_PM_ERASE      2'h1
`define EEAC_PM_WRITE      2'h2

// =====================================================================
// reset values
`define EEAC_DATA_RST      8'h00
`define EEAC_ADDR_RST      9'h000
`define EEAC_PM_RST        2'h0

// =====================================================================
// timing counts
`define EEAC_ARM_CYCLES    3'h4
`define EEAC_WSTALL_CYCLES 3'h2
`define EEAC_RSTALL_CYCLES 3'h4
`define EEAC_WRITE_OSC     26368
`define EEAC_WRITE_TYP_US  3300

`endif

// ### verilog/eeac_write_timer.v
// eeprom access control: self-timed write length counter
`include "eeac_defines.vh"

module eeac_write_timer #(
    parameter CNT_W     = 15,
    parameter WRITE_OSC = `EEAC_WRITE_OSC
) (
    // clock and reset
    input  wire mclk,
    input  wire rstn,
    // oscillator tick, already synchronised
    input  wire oscTick,
    // control
    input  wire start,
    output reg  done
);

    // =================================================================
    // counter
    reg [CNT_W-1:0] cnt_q;
    reg             run_q;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= {CNT_W{1'b0}};
            run_q <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= {CNT_W{1'b0}};
                run_q <= 1'b1;
            end else if (run_q && oscTick) begin
                if (cnt_q == WRITE_OSC[CNT_W-1:0] - 1'b1) begin
                    run_q <= 1'b0;
                    done  <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

// ### verilog/eeac_sync.v
// eeprom access control: two-flop level synchroniser
module eeac_sync (
    // clock and reset
    input  wire mclk,
    input  wire rstn,
    // level
    input  wire din,
    output reg  dout
);

    // =================================================================
    // stages
    reg meta_q;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

// ### verilog/eeac_top.v
// eeprom access control: axi4-lite registers, arming, stall and timing
`include "eeac_defines.vh"

// Function
// - write starts only with master enable armed
// - strobe accepted only inside four-cycle window
// - no eeprom write during flash write
// - window expiry makes write fail
// - hardware clears write strobe when done
// - write stalls cpu two cycles
// - read strobe loads data at address
// - read stalls cpu four cycles
// - busy ignores read, blocks address change
// - write lasts 26368 oscillator cycles
// - raw pin reset aborts running write, system reset does not
// - master enable self-clears after four cycles
// - mode selects action, frozen while busy
// - ready request while strobe low, enabled
// - nine-bit linear byte address
module eeac_top #(
    parameter WRITE_OSC = `EEAC_WRITE_OSC
) (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // axi4-lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // axi4-lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    // axi4-lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // system inputs (asynchronous)
    input  wire        rcOscTick,
    input  wire        selfProgramEnable,
    input  wire        globalIrqEnable,
    // eeprom array port
    output reg  [8:0]  arrAddr,
    output reg  [7:0]  arrWdata,
    output reg  [1:0]  arrMode,
    output reg         arrProgram,
    input  wire [7:0]  arrRdata,
    // cpu side
    output reg         cpuStall,
    output reg         readyIrq
);

    // =================================================================
    // reset release
    reg rstMeta_q;
    reg rstn;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstn      <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstn      <= rstMeta_q;
        end
    end

    // =================================================================
    // input synchronisers
    wire oscLvl;
    wire spmBusy;
    wire gie;
    reg  oscLvl_q;

    eeac_sync uSyncOsc (
        .mclk (mclk),
        .rstn (rstn),
        .din  (rcOscTick),
        .dout (oscLvl)
    );
    eeac_sync uSyncSpm (
        .mclk (mclk),
        .rstn (rstn),
        .din  (selfProgramEnable),
        .dout (spmBusy)
    );
    eeac_sync uSyncGie (
        .mclk (mclk),
        .rstn (rstn),
        .din  (globalIrqEnable),
        .dout (gie)
    );

    // oscillator edge seen only after both sync flops
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) oscLvl_q <= 1'b0;
        else       oscLvl_q <= oscLvl;
    end
    wire oscTick = oscLvl & ~oscLvl_q;

    // =================================================================
    // axi4-lite handshake
    reg  [11:0] awAddr_q;
    reg  [31:0] wData_q;
    reg  [3:0]  wStrb_q;
    reg         awHave_q;
    reg         wHave_q;
    wire        wrFire = awHave_q & wHave_q & ~s_axi_bvalid;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awAddr_q      <= 12'h000;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
            awHave_q      <= 1'b0;
            wHave_q       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q      <= s_axi_awaddr;
                awHave_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                wHave_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q[11:4] == 8'h00 &&
                                 awAddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    wire       wrAddr = wrFire && (awAddr_q == `EEAC_ADDR_OFS);
    wire       wrData = wrFire && (awAddr_q == `EEAC_DATA_OFS) && wStrb_q[0];
    wire       wrCtrl = wrFire && (awAddr_q == `EEAC_CTRL_OFS) && wStrb_q[0];
    wire [7:0] wb0    = wData_q[7:0];

    // =================================================================
    // control state
    reg  [8:0] eeAddress_q;
    reg  [7:0] eeData_q;
    reg  [1:0] programMode_q;
    reg        readyIrqEnable_q;
    reg        masterWriteEnable_q;
    reg  [2:0] armCnt_q;
    reg        writeStrobe_q;
    reg  [2:0] stallCnt_q;
    reg        timerStart;
    wire       timerDone;

    wire wantWrite = wrCtrl && wb0[`EEAC_CTRL_WSTRB];
    wire goWrite   = wantWrite && masterWriteEnable_q && !writeStrobe_q &&
                     !spmBusy;
    wire goRead    = wrCtrl && wb0[`EEAC_CTRL_RSTRB] && !writeStrobe_q &&
                     !goWrite;

    // reset clears the arming and config bits but never a running write
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            eeData_q            <= `EEAC_DATA_RST;
            readyIrqEnable_q    <= 1'b0;
            masterWriteEnable_q <= 1'b0;
            armCnt_q            <= 3'h0;
            stallCnt_q          <= 3'h0;
            timerStart          <= 1'b0;
        end else begin
            timerStart <= goWrite;
            if (wrData)
                eeData_q <= wb0;
            else if (goRead)
                eeData_q <= arrRdata;
            if (wrCtrl)
                readyIrqEnable_q <= wb0[`EEAC_CTRL_RIE];
            if (wrCtrl && wb0[`EEAC_CTRL_MWE] && !wb0[`EEAC_CTRL_WSTRB]) begin
                masterWriteEnable_q <= 1'b1;
                armCnt_q            <= `EEAC_ARM_CYCLES;
            end else if (goWrite) begin
                masterWriteEnable_q <= 1'b0;
                armCnt_q            <= 3'h0;
            end else if (armCnt_q != 3'h0) begin
                armCnt_q <= armCnt_q - 3'h1;
                if (armCnt_q == 3'h1)
                    masterWriteEnable_q <= 1'b0;
            end
            if (goWrite)
                stallCnt_q <= `EEAC_WSTALL_CYCLES;
            else if (goRead)
                stallCnt_q <= `EEAC_RSTALL_CYCLES;
            else if (stallCnt_q != 3'h0)
                stallCnt_q <= stallCnt_q - 3'h1;
        end
    end

    // =================================================================
    // write busy state, kept across the system reset
    // only the raw pin reset clears these, except the mode, which the system reset also clears while no write runs
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            writeStrobe_q <= 1'b0;
            eeAddress_q   <= `EEAC_ADDR_RST;
            programMode_q <= `EEAC_PM_RST;
        end else if (!rstn) begin
            if (!writeStrobe_q)
                programMode_q <= `EEAC_PM_RST;
        end else begin
            if (goWrite)
                writeStrobe_q <= 1'b1;
            else if (timerDone)
                writeStrobe_q <= 1'b0;
            if (wrAddr && !writeStrobe_q && wStrb_q[0])
                eeAddress_q[7:0] <= wData_q[7:0];
            if (wrAddr && !writeStrobe_q && wStrb_q[1])
                eeAddress_q[8] <= wData_q[8];
            if (wrCtrl && !writeStrobe_q)
                programMode_q <= wb0[`EEAC_CTRL_PM_HI:`EEAC_CTRL_PM_LO];
        end
    end

    // timer also runs on the raw reset so a write survives
    eeac_write_timer #(
        .CNT_W     (15),
        .WRITE_OSC (WRITE_OSC)
    ) uTimer (
        .mclk    (mclk),
        .rstn    (resetn),
        .oscTick (oscTick),
        .start   (timerStart),
        .done    (timerDone)
    );

    // =================================================================
    // outputs
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arrAddr    <= 9'h000;
            arrWdata   <= 8'h00;
            arrMode    <= 2'h0;
            arrProgram <= 1'b0;
            cpuStall   <= 1'b0;
            readyIrq   <= 1'b0;
        end else begin
            arrAddr    <= eeAddress_q;
            if (goWrite) begin
                arrWdata <= eeData_q;
                arrMode  <= programMode_q;
            end
            arrProgram <= writeStrobe_q;
            cpuStall   <= goWrite | goRead | (stallCnt_q > 3'h1);
            readyIrq   <= readyIrqEnable_q & gie & ~writeStrobe_q &
                          ~goWrite & ~spmBusy;
        end
    end

    // =================================================================
    // axi4-lite read
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
                `EEAC_ADDR_OFS: s_axi_rdata <= {23'h000000, eeAddress_q};
                `EEAC_DATA_OFS: s_axi_rdata <= {24'h000000, eeData_q};
                `EEAC_CTRL_OFS: s_axi_rdata <= {26'h0000000, programMode_q,
                    readyIrqEnable_q, masterWriteEnable_q, writeStrobe_q,
                    1'b0};
                `EEAC_STAT_OFS: s_axi_rdata <= {29'h00000000, readyIrq,
                    spmBusy, writeStrobe_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ### sim/eeac_top_assertions.sv
// eeprom access control: port-level checker bound to the top module
module eeac_top_assertions #(
    parameter WRITE_OSC = 26368
) (
    // clock and reset
    input wire        mclk,
    input wire        resetn,
    // axi4-lite handshakes
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    // system inputs
    input wire        rcOscTick,
    input wire        selfProgramEnable,
    // array and cpu side
    input wire [8:0]  arrAddr,
    input wire [7:0]  arrWdata,
    input wire [1:0]  arrMode,
    input wire        arrProgram,
    input wire        cpuStall,
    input wire        readyIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0]  oscS_q;
    logic [15:0] oscCnt_q;

    // =================================================================
    // oscillator edges seen during a write, resynchronised here
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            oscS_q   <= 3'h0;
            oscCnt_q <= 16'h0;
        end else begin
            oscS_q <= {oscS_q[1:0], rcOscTick};
            if (!arrProgram)
                oscCnt_q <= 16'h0;
            else if (oscS_q[1] && !oscS_q[2])
                oscCnt_q <= oscCnt_q + 16'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // =================================================================
    // properties
    sequence s_stall2;
        cpuStall [*2] ##1 !cpuStall;
    endsequence
    sequence s_stall4;
        cpuStall [*4] ##1 !cpuStall;
    endsequence
    property p_stallLen;
        $rose(cpuStall) |-> s_stall2 or s_stall4;
    endproperty
    // a write start shows exactly two stall cycles around it
    sequence s_wrStall;
        cpuStall && $past(cpuStall) && !$past(cpuStall, 2) ##1 !cpuStall;
    endsequence
    property p_progStall;
        $rose(arrProgram) |-> s_wrStall;
    endproperty
    property p_spmBlock;
        selfProgramEnable [*4] |=> !$rose(arrProgram);
    endproperty
    property p_spmNoIrq;
        selfProgramEnable [*4] |=> !readyIrq;
    endproperty
    property p_irqBusy;
        arrProgram && $past(arrProgram) |-> !readyIrq;
    endproperty
    property p_freeze;
        arrProgram && $past(arrProgram) |->
            $stable(arrMode) && $stable(arrAddr) && $stable(arrWdata);
    endproperty
    // one oscillator edge of slack for the synchroniser skew
    property p_progLen;
        $fell(arrProgram) |->
            oscCnt_q >= WRITE_OSC - 1 && oscCnt_q <= WRITE_OSC + 1;
    endproperty
    property p_bOnce;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_rAfterAr;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty

    a_stallLen: assert property (p_stallLen)
        else $error("cpu stall length wrong");
    a_progStall: assert property (p_progStall)
        else $error("write start without two-cycle stall");
    a_spmBlock: assert property (p_spmBlock)
        else $error("write started during flash write");
    a_spmNoIrq: assert property (p_spmNoIrq)
        else $error("ready request during flash write");
    a_irqBusy: assert property (p_irqBusy)
        else $error("ready request during eeprom write");
    a_freeze: assert property (p_freeze)
        else $error("array inputs changed during write");
    a_progLen: assert property (p_progLen)
        else $error("write length wrong");
    a_bOnce: assert property (p_bOnce)
        else $error("write response repeated");
    a_rAfterAr: assert property (p_rAfterAr)
        else $error("read data without read address");
endmodule

bind eeac_top eeac_top_assertions #(.WRITE_OSC(WRITE_OSC)) u_chk (
    .mclk, .resetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .rcOscTick, .selfProgramEnable,
    .arrAddr, .arrWdata, .arrMode, .arrProgram, .cpuStall, .readyIrq
);

// ### sim/eeac_array_model.sv
// eeprom access control: behavioural byte array on the far side
module eeac_array_model (
    // clock
    input  wire        mclk,
    // array port
    input  wire [8:0]  arrAddr,
    input  wire [7:0]  arrWdata,
    input  wire [1:0]  arrMode,
    input  wire        arrProgram,
    output wire [7:0]  arrRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:511];
    logic       prog_q = 1'h0;

    initial begin
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0] ^ 8'h5A;
    end

    assign arrRdata = mem[arrAddr];

    // =================================================================
    // programming only clears bits unless the cell is erased first
    always @(posedge mclk) begin
        prog_q <= arrProgram;
        if (arrProgram && !prog_q) begin
            case (arrMode)
                2'h0: mem[arrAddr] <= arrWdata;
                2'h1: mem[arrAddr] <= 8'hFF;
                2'h2: mem[arrAddr] <= mem[arrAddr] & arrWdata;
                default: ;
            endcase
        end
    end
endmodule

// ### sim/tb_top.sv
// eeprom access control: self-checking testbench
`include "eeac_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'h0, resetn = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        rcOscTick = 1'h0, selfProgramEnable = 1'h0;
    logic        globalIrqEnable = 1'h1;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire         arrProgram, cpuStall, readyIrq;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, arrMode;
    wire  [31:0] s_axi_rdata;
    wire  [8:0]  arrAddr;
    wire  [7:0]  arrWdata, arrRdata;
    int          n_fail = 0, comparisons = 0;
    logic [31:0] rdat;

    eeac_top #(.WRITE_OSC(20)) dut (
        .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .rcOscTick, .selfProgramEnable,
        .globalIrqEnable, .arrAddr, .arrWdata, .arrMode, .arrProgram,
        .arrRdata, .cpuStall, .readyIrq
    );
    eeac_array_model u_mem (
        .mclk, .arrAddr, .arrWdata, .arrMode, .arrProgram, .arrRdata
    );

    initial forever #25 mclk = ~mclk;
    // odd half period keeps the oscillator unrelated to mclk
    initial forever #173 rcOscTick = ~rcOscTick;

    // =================================================================
    // checking and bus tasks; each is entered just after a rising edge
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        logic aw, w;
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'h1;
        s_axi_wdata   <= d;
        aw = 1'h0;
        w = 1'h0;
        while (!(aw && w)) begin
            @(posedge mclk);
            if (!aw && s_axi_awready) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] er = 2'h0);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr  <= a;
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
        rdat = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic waitIdle;
        for (int n = 0; n < 100; n++) begin
            rd(`EEAC_STAT_OFS);
            if (rdat[1:0] === 2'h0) break;
        end
        chk({30'h0, rdat[1:0]}, 32'h0);
    endtask
    task automatic eeWrite(input logic [8:0] a, input logic [7:0] d,
                           input logic [5:0] c);
        waitIdle();
        wr(`EEAC_ADDR_OFS, {23'h0, a});
        wr(`EEAC_DATA_OFS, {24'h0, d});
        wr(`EEAC_CTRL_OFS, {26'h0, c | 6'h04});
        wr(`EEAC_CTRL_OFS, {26'h0, c | 6'h06});
    endtask
    task automatic eeRead(input logic [8:0] a);
        wr(`EEAC_ADDR_OFS, {23'h0, a});
        wr(`EEAC_CTRL_OFS, 32'h1);
        rd(`EEAC_DATA_OFS);
    endtask

    // =================================================================
    // scenarios
    task t_reset;
        rd(`EEAC_ADDR_OFS);
        chk(rdat, 32'h0);
        rd(`EEAC_DATA_OFS);
        chk(rdat, 32'h0);
        rd(`EEAC_CTRL_OFS);
        chk(rdat, 32'h0);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h0);
        rd(12'h010, 2'h2);
        wr(12'h010, 32'hFF, 2'h2);
    endtask
    task t_modes;
        logic [7:0] wd [3] = '{8'hA5, 8'h00, 8'h3C};
        logic [7:0] ex [3] = '{8'hA5, 8'hFF, 8'h3C};
        for (int i = 0; i < 3; i++) begin
            eeWrite(9'h1FF, wd[i], {i[1:0], 4'h0});
            waitIdle();
            eeRead(9'h1FF);
            chk(rdat, {24'h0, ex[i]});
        end
        eeRead(9'h012);
        chk(rdat, 32'h48);
        wr(`EEAC_ADDR_OFS, 32'hFFFF);
        rd(`EEAC_ADDR_OFS);
        chk(rdat, 32'h1FF);
    endtask
    task t_refuse;
        wr(`EEAC_DATA_OFS, 32'h77);
        wr(`EEAC_CTRL_OFS, 32'h2);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h0);
        wr(`EEAC_CTRL_OFS, 32'h4);
        repeat (6) @(posedge mclk);
        rd(`EEAC_CTRL_OFS);
        chk(rdat, 32'h0);
        wr(`EEAC_CTRL_OFS, 32'h6);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h0);
        eeRead(9'h1FF);
        chk(rdat, 32'h3C);
    endtask
    task t_busy;
        eeWrite(9'h005, 8'hC3, 6'h08);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h1);
        wr(`EEAC_ADDR_OFS, 32'h0AA);
        wr(`EEAC_CTRL_OFS, 32'h19);
        rd(`EEAC_DATA_OFS);
        chk(rdat, 32'hC3);
        waitIdle();
        rd(`EEAC_ADDR_OFS);
        chk(rdat, 32'h005);
        rd(`EEAC_CTRL_OFS);
        chk(rdat, 32'h08);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h4);
        chk({31'h0, readyIrq}, 32'h1);
        globalIrqEnable <= 1'h0;
        repeat (5) @(posedge mclk);
        chk({31'h0, readyIrq}, 32'h0);
        eeRead(9'h005);
        chk(rdat, 32'hC3);
    endtask
    // ready request enabled so only the flash-busy mask can hold it low
    task t_spm;
        selfProgramEnable <= 1'h1;
        globalIrqEnable   <= 1'h1;
        repeat (4) @(posedge mclk);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h2);
        wr(`EEAC_CTRL_OFS, 32'hC);
        wr(`EEAC_CTRL_OFS, 32'hE);
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h2);
        chk({31'h0, readyIrq}, 32'h0);
        selfProgramEnable <= 1'h0;
        waitIdle();
        rd(`EEAC_STAT_OFS);
        chk(rdat, 32'h4);
    endtask

    task final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'h1;
        repeat (5) @(posedge mclk);
        t_reset();
        t_modes();
        t_refuse();
        t_busy();
        t_spm();
        final_report();
    end
endmodule
